// ### verilog/mbs_params.svh
// Constants of the motor brake sequencer: offsets, fields, resets, timing.
`ifndef MBS_PARAMS_SVH
`define MBS_PARAMS_SVH
`define MBS_CLK_NS        40
`define MBS_MS_NS         1000000
`define MBS_MS_PER_S      1000
`define MBS_BOOST_MAX_S   2
`define MBS_HOLD_BOOST_S  2
`define MBS_ADR_CTRL      8'h00
`define MBS_ADR_ECO_DLY   8'h04
`define MBS_ADR_SW_DLY    8'h08
`define MBS_ADR_STATUS    8'h0C
`define MBS_ADR_INT_STAT  8'h10
`define MBS_ADR_INT_MASK  8'h14
`define MBS_ADR_CTL_PAR   8'h18
`define MBS_CTRL_BRAKE    0
`define MBS_CTRL_ECO      1
`define MBS_CTRL_CL       2
`define MBS_CTRL_RST      3'h0
`define MBS_ECO_DLY_RST   16'h0064
`define MBS_SW_DLY_RST    16'h0064
`define MBS_EV_REL        0
`define MBS_EV_APPLY      1
`define MBS_EV_BOOST      2
`define MBS_EV_CLREF      3
`define MBS_EV_LREJ       4
`define MBS_EV_TUNE       5
`define MBS_EV_W          6
`define MBS_RESP_OK       2'h0
`define MBS_RESP_ERR      2'h2
`endif

// ### verilog/mbs_pkg.sv
// Types shared by the motor brake sequencer.
package mbs_pkg;
   typedef enum logic [2:0] {
      ST_OFF,
      ST_RUN,
      ST_ECO_WAIT,
      ST_ENGAGE,
      ST_PARK
   } mbs_state_e;
endpackage

// ### verilog/mbs_ms_tick.sv
// Millisecond enable pulse derived from the system clock.
`timescale 1ns/100ps
`default_nettype none
module mbs_ms_tick #(
   parameter int CYC_PER_MS = 25000
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   output var  logic tick
);
   localparam int CW = $clog2(CYC_PER_MS + 1);
   localparam logic [CW-1:0] LAST = CW'(CYC_PER_MS - 1);

   logic [CW-1:0] cnt_q;

   // Free running divider; one cycle high per millisecond.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         tick  <= (cnt_q == LAST);
         cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
      end
   end
endmodule
`default_nettype wire

// ### verilog/mbs_brake_seq.sv
// Motor brake sequencer with current limits and AXI4-Lite registers.
`include "mbs_params.svh"
`timescale 1ns/100ps
`default_nettype none
module mbs_brake_seq #(
   parameter int CYC_PER_MS = `MBS_MS_NS / `MBS_CLK_NS,
   parameter int ADDR_W     = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output var  logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output var  logic              s_axi_wready,
   output var  logic [1:0]        s_axi_bresp,
   output var  logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output var  logic              s_axi_arready,
   output var  logic [31:0]       s_axi_rdata,
   output var  logic [1:0]        s_axi_rresp,
   output var  logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              drive_enable_input,
   input  wire logic              fault_in,
   input  wire logic              load_voltage_ok,
   input  wire logic              motion_active,
   input  wire logic              accel_phase,
   input  wire logic              enc_configured,
   input  wire logic              enc_connected,
   input  wire logic              fieldbus_active,
   input  wire logic              local_wr_valid,
   input  wire logic [ADDR_W-1:0] local_wr_addr,
   input  wire logic [31:0]       local_wr_data,
   input  wire logic              tune_done,
   input  wire logic [15:0]       tune_kp,
   input  wire logic [15:0]       tune_ki,
   output var  logic              brake_out,
   output var  logic              current_on,
   output var  logic              boost_en,
   output var  logic              current_cap,
   output var  logic              closed_loop_on,
   output var  logic [15:0]       ctl_kp,
   output var  logic [15:0]       ctl_ki,
   output var  logic              irq
);
   localparam logic [11:0] BOOST_MS =
      12'(`MBS_BOOST_MAX_S * `MBS_MS_PER_S);
   localparam logic [11:0] HOLD_MS =
      12'(`MBS_HOLD_BOOST_S * `MBS_MS_PER_S);

   // Byte lanes of a write merged into the old register value.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Word address of a byte address, low two bits dropped.
   function automatic logic [7:0] word_adr(input logic [ADDR_W-1:0] a);
      return {a[7:2], 2'b00};
   endfunction

   logic                   tick;
   mbs_pkg::mbs_state_e    state_q, state_d;
   logic [15:0]            dly_q, eco_dly_q, sw_dly_q;
   logic [11:0]            boost_ms_q, hold_ms_q;
   logic [2:0]             ctrl_q;
   logic [`MBS_EV_W-1:0]   int_stat_q, int_mask_q, ev;
   logic                   aw_full_q, w_full_q, clref_q;
   logic [ADDR_W-1:0]      aw_adr_q;
   logic [31:0]            w_dat_q;
   logic [3:0]             w_strb_q;

   mbs_ms_tick #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick)
   );

   // Write channel decode; address and data are taken in either order.
   wire aw_take  = s_axi_awvalid && s_axi_awready;
   wire w_take   = s_axi_wvalid && s_axi_wready;
   wire wr_fire  = aw_full_q && w_full_q && !s_axi_bvalid;
   wire aw_full_d = (aw_full_q || aw_take) && !wr_fire;
   wire w_full_d  = (w_full_q || w_take) && !wr_fire;
   wire [7:0] wa  = word_adr(aw_adr_q);
   wire wa_cfg = (wa == `MBS_ADR_CTRL) || (wa == `MBS_ADR_ECO_DLY) ||
                 (wa == `MBS_ADR_SW_DLY);
   wire wa_ok  = wa_cfg || (wa == `MBS_ADR_INT_MASK);
   // Config is locked while enabled so settings never shift under a move.
   wire wa_lock = wa_cfg && drive_enable_input;
   wire axi_we  = wr_fire && wa_ok && !wa_lock;
   // Local writes lose to the fieldbus and to a same-cycle bus write.
   wire loc_rej = local_wr_valid && (fieldbus_active || axi_we);
   wire [7:0] la = word_adr(local_wr_addr);
   wire loc_we = local_wr_valid && !loc_rej && !drive_enable_input;
   wire cfg_we = axi_we || loc_we;
   wire [7:0] cfg_a = axi_we ? wa : la;
   wire [31:0] cfg_d = axi_we ?
                       merge(32'h0000_0000, w_dat_q, w_strb_q) :
                       local_wr_data;
   wire [3:0] cfg_s = axi_we ? w_strb_q : 4'hF;

   // Read channel and read-to-clear of the interrupt status.
   wire ar_take  = s_axi_arvalid && s_axi_arready;
   wire rvalid_d = ar_take || (s_axi_rvalid && !s_axi_rready);
   wire [7:0] ra = word_adr(s_axi_araddr);
   wire rd_clr   = ar_take && (ra == `MBS_ADR_INT_STAT);

   // Run permission and the stop causes that end it.
   wire stop_hard = fault_in || !load_voltage_ok;
   wire run_ok    = drive_enable_input && !stop_hard;
   wire brake_en  = ctrl_q[`MBS_CTRL_BRAKE];
   wire eco_en    = ctrl_q[`MBS_CTRL_ECO] && brake_en;
   wire enc_ok    = enc_configured && enc_connected;

   // Brake sequencing state machine.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         mbs_pkg::ST_OFF: begin
            if (run_ok) begin
               state_d = mbs_pkg::ST_RUN;
            end
         end
         mbs_pkg::ST_RUN: begin
            if (stop_hard || (!run_ok && !brake_en)) begin
               state_d = mbs_pkg::ST_OFF;
            end else if (!run_ok) begin
               state_d = mbs_pkg::ST_ENGAGE;
            end else if (eco_en && !motion_active) begin
               state_d = mbs_pkg::ST_ECO_WAIT;
            end
         end
         mbs_pkg::ST_ECO_WAIT: begin
            if (stop_hard) begin
               state_d = mbs_pkg::ST_OFF;
            end else if (!run_ok || dly_q >= eco_dly_q) begin
               state_d = mbs_pkg::ST_ENGAGE;
            end else if (motion_active) begin
               state_d = mbs_pkg::ST_RUN;
            end
         end
         mbs_pkg::ST_ENGAGE: begin
            if (stop_hard) begin
               state_d = mbs_pkg::ST_OFF;
            end else if (dly_q >= sw_dly_q) begin
               state_d = !run_ok ? mbs_pkg::ST_OFF :
                         motion_active ? mbs_pkg::ST_RUN :
                         mbs_pkg::ST_PARK;
            end
         end
         mbs_pkg::ST_PARK: begin
            if (!run_ok) begin
               state_d = mbs_pkg::ST_OFF;
            end else if (motion_active) begin
               state_d = mbs_pkg::ST_RUN;
            end
         end
      endcase
   end

   // Output terms; the brake only opens while running is still allowed.
   wire st_open  = (state_q == mbs_pkg::ST_RUN) ||
                   (state_q == mbs_pkg::ST_ECO_WAIT);
   wire brake_d  = brake_en && st_open && run_ok;
   wire cur_d    = !stop_hard && (st_open ||
                   (state_q == mbs_pkg::ST_ENGAGE));
   wire [15:0] dly_d = (state_d != state_q) ? 16'h0000 :
                       (tick && dly_q != 16'hFFFF) ? dly_q + 16'h0001 :
                       dly_q;
   wire boost_d  = accel_phase && cur_d && (boost_ms_q < BOOST_MS);
   wire hold_d   = closed_loop_on && !motion_active && cur_d &&
                   (hold_ms_q < HOLD_MS);
   wire cl_d     = ctrl_q[`MBS_CTRL_CL] && enc_ok;
   wire clref_d  = ctrl_q[`MBS_CTRL_CL] && !enc_ok;

   // Events that set the sticky status bits.
   always_comb begin
      ev = '0;
      ev[`MBS_EV_REL]   = brake_d && !brake_out;
      ev[`MBS_EV_APPLY] = !brake_d && brake_out;
      ev[`MBS_EV_BOOST] = tick && accel_phase &&
                          (boost_ms_q == BOOST_MS - 12'h001);
      ev[`MBS_EV_CLREF] = clref_d && !clref_q;
      ev[`MBS_EV_LREJ]  = loc_rej;
      ev[`MBS_EV_TUNE]  = tune_done;
   end
   wire [`MBS_EV_W-1:0] stat_d =
      (int_stat_q & ~(rd_clr ? {`MBS_EV_W{1'b1}} : '0)) | ev;

   wire [31:0] rd_word =
      (ra == `MBS_ADR_CTRL)     ? {29'h0, ctrl_q} :
      (ra == `MBS_ADR_ECO_DLY)  ? {16'h0000, eco_dly_q} :
      (ra == `MBS_ADR_SW_DLY)   ? {16'h0000, sw_dly_q} :
      (ra == `MBS_ADR_STATUS)   ? {24'h0, 3'(state_q), closed_loop_on,
                                   current_cap, boost_en, current_on,
                                   brake_out} :
      (ra == `MBS_ADR_INT_STAT) ? {26'h0, int_stat_q} :
      (ra == `MBS_ADR_INT_MASK) ? {26'h0, int_mask_q} :
      {ctl_ki, ctl_kp};
   wire ra_ok = (ra <= `MBS_ADR_CTL_PAR);

   // AXI handshake registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `MBS_RESP_OK;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `MBS_RESP_OK;
         aw_adr_q      <= '0;
         w_dat_q       <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
      end else begin
         aw_full_q     <= aw_full_d;
         w_full_q      <= w_full_d;
         s_axi_awready <= !aw_full_d;
         s_axi_wready  <= !w_full_d;
         if (aw_take) begin
            aw_adr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            w_dat_q  <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= axi_we ? `MBS_RESP_OK : `MBS_RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !rvalid_d;
         s_axi_rvalid  <= rvalid_d;
         if (ar_take) begin
            s_axi_rdata <= ra_ok ? rd_word : 32'h0000_0000;
            s_axi_rresp <= ra_ok ? `MBS_RESP_OK : `MBS_RESP_ERR;
         end
      end
   end

   // Configuration and interrupt registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q     <= `MBS_CTRL_RST;
         eco_dly_q  <= `MBS_ECO_DLY_RST;
         sw_dly_q   <= `MBS_SW_DLY_RST;
         int_mask_q <= '0;
         int_stat_q <= '0;
         irq        <= 1'b0;
      end else begin
         if (cfg_we && cfg_a == `MBS_ADR_CTRL) begin
            ctrl_q <= 3'(merge({29'h0, ctrl_q}, cfg_d, cfg_s));
         end
         if (cfg_we && cfg_a == `MBS_ADR_ECO_DLY) begin
            eco_dly_q <= 16'(merge({16'h0, eco_dly_q}, cfg_d, cfg_s));
         end
         if (cfg_we && cfg_a == `MBS_ADR_SW_DLY) begin
            sw_dly_q <= 16'(merge({16'h0, sw_dly_q}, cfg_d, cfg_s));
         end
         if (cfg_we && cfg_a == `MBS_ADR_INT_MASK) begin
            int_mask_q <= `MBS_EV_W'(merge({26'h0, int_mask_q}, cfg_d,
                                           cfg_s));
         end
         // A new event in the clearing read cycle survives the clear.
         int_stat_q <= stat_d;
         irq        <= |(stat_d & int_mask_q);
      end
   end

   // Sequencer state, timers and drive outputs.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q        <= mbs_pkg::ST_OFF;
         dly_q          <= 16'h0000;
         boost_ms_q     <= 12'h000;
         hold_ms_q      <= 12'h000;
         brake_out      <= 1'b0;
         current_on     <= 1'b0;
         boost_en       <= 1'b0;
         current_cap    <= 1'b1;
         closed_loop_on <= 1'b0;
         clref_q        <= 1'b0;
         ctl_kp         <= 16'h0000;
         ctl_ki         <= 16'h0000;
      end else begin
         state_q        <= state_d;
         dly_q          <= dly_d;
         boost_ms_q     <= !(accel_phase && cur_d) ? 12'h000 :
                           (tick && boost_ms_q < BOOST_MS) ?
                           boost_ms_q + 12'h001 : boost_ms_q;
         hold_ms_q      <= (motion_active || !closed_loop_on) ? 12'h000 :
                           (tick && hold_ms_q < HOLD_MS) ?
                           hold_ms_q + 12'h001 : hold_ms_q;
         brake_out      <= brake_d;
         current_on     <= cur_d;
         boost_en       <= boost_d;
         current_cap    <= !(boost_d || hold_d);
         closed_loop_on <= cl_d;
         clref_q        <= clref_d;
         if (tune_done) begin
            ctl_kp <= tune_kp;
            ctl_ki <= tune_ki;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_start;
      state_q == mbs_pkg::ST_OFF && run_ok && brake_en;
   endsequence
   sequence s_park;
      state_q == mbs_pkg::ST_ENGAGE ##1 state_q == mbs_pkg::ST_PARK;
   endsequence

   chk_enable_release: assert property (s_start ##1 run_ok |=> brake_out)
      else $error("brake not released after enable");
   chk_stop_applies: assert property (!run_ok |=> !brake_out)
      else $error("brake still released after stop cause");
   chk_eco_park: assert property (s_park |=> !current_on && !brake_out)
      else $error("idle park left current or brake on");
   chk_eco_delay: assert property (state_q == mbs_pkg::ST_ECO_WAIT &&
      run_ok && !motion_active && dly_q < eco_dly_q
      |=> state_q != mbs_pkg::ST_ENGAGE)
      else $error("idle delay cut short");
   chk_switch_hold: assert property (state_q == mbs_pkg::ST_ENGAGE &&
      !stop_hard && dly_q < sw_dly_q |=> current_on && !brake_out)
      else $error("current dropped during switching delay");
   chk_boost_phase: assert property (boost_en |-> $past(accel_phase) &&
      $past(boost_ms_q) < BOOST_MS)
      else $error("boost outside phase or over limit");
   chk_hold_cap: assert property (closed_loop_on && !motion_active &&
      !accel_phase && hold_ms_q == HOLD_MS |=> current_cap)
      else $error("holding current not capped after limit");
   chk_cl_encoder: assert property (closed_loop_on |-> $past(enc_ok))
      else $error("closed loop without encoder");
   chk_local_reject: assert property (local_wr_valid && fieldbus_active
      |=> int_stat_q[`MBS_EV_LREJ] && $stable(ctrl_q))
      else $error("local write not rejected");
   chk_tune_apply: assert property (tune_done |=> ctl_kp == $past(tune_kp))
      else $error("tuned parameters not applied");
endmodule
`default_nettype wire

// ### verification/mbs_motor_model.sv
// Behavioural model of the holding brake, windings and motion source.
`timescale 1ns/100ps
`default_nettype none
module mbs_motor_model (
   input  wire logic aclk,
   input  wire logic move_cmd,
   input  wire logic brake_out,
   input  wire logic current_on,
   output var  logic motion_active
);
   logic [1:0] rel_q = 2'b00;
   // The armature lags its coil by two cycles, so a move can never start
   // in the same cycle that the drive releases the brake.
   always_ff @(posedge aclk) begin
      rel_q <= {rel_q[0], brake_out};
   end
   // A move runs only while the shaft is free and the windings are fed.
   assign motion_active = move_cmd & rel_q[1] & current_on;
endmodule
`default_nettype wire

// ### verification/motor_brake_sequencer_tb.sv
// Self-checking bench for the motor brake sequencer.
`include "mbs_params.svh"
`timescale 1ns/100ps
`default_nettype none
module motor_brake_sequencer_tb;
   localparam int CPM = 4;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr, lw_addr;
   logic [31:0] wdata, lw_data, rnd;
   logic [1:0]  bresp, rresp;
   logic        awready, wready, bvalid, arready, rvalid, tdone, lw_v;
   logic        en, fault, volt, motion, accel, ecfg, econ, fbus, move;
   logic [15:0] tkp, tki, kp, ki;
   logic [31:0] rdata;
   logic        brake, cur, boost, cap, cl, irq;
   int          fail_count, total_checks;

   mbs_brake_seq #(.CYC_PER_MS(CPM), .ADDR_W(8)) mbs_brake_seq_inst (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .drive_enable_input(en), .fault_in(fault),
      .load_voltage_ok(volt), .motion_active(motion),
      .accel_phase(accel), .enc_configured(ecfg), .enc_connected(econ),
      .fieldbus_active(fbus), .local_wr_valid(lw_v),
      .local_wr_addr(lw_addr), .local_wr_data(lw_data),
      .tune_done(tdone), .tune_kp(tkp), .tune_ki(tki),
      .brake_out(brake), .current_on(cur), .boost_en(boost),
      .current_cap(cap), .closed_loop_on(cl), .ctl_kp(kp), .ctl_ki(ki),
      .irq(irq));

   mbs_motor_model mbs_motor_model_inst (
      .aclk(aclk), .move_cmd(move), .brake_out(brake), .current_on(cur),
      .motion_active(motion));

   // Free-running system clock.
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // One AXI write; address and data are offered together and each is
   // released at the edge that takes it.
   // The master never gives up on a slow slave; only the watchdog ends a
   // wait, so a hung handshake is reported instead of silently skipped.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      check(bresp, er);
   endtask

   // Expected read response: a slave error only above the last offset.
   function automatic logic [1:0] exp_rresp(input logic [7:0] a);
      return (a > `MBS_ADR_CTL_PAR) ? `MBS_RESP_ERR : `MBS_RESP_OK;
   endfunction

   // One AXI read; the data is taken at the edge that sees rvalid high.
   task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      check(rresp, exp_rresp(a));
      check(rdata & m, e);
   endtask

   task automatic lwr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      lw_v <= 1'b1;
      lw_addr <= a;
      lw_data <= d;
      @(posedge aclk);
      lw_v <= 1'b0;
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Watchdog sized well above the roughly 8400 cycles the tests take.
   initial begin
      #(40 * 20000);
      fail_count++;
      report_and_stop;
   end

   // Main sequence; every operator setting change except the interrupt mask happens with enable low.
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, lw_v, tdone} = 0;
      {en, fault, accel, ecfg, econ, fbus, move} = 0;
      {awaddr, araddr, lw_addr, wdata, lw_data, tkp, tki} = 0;
      volt = 1'b1;
      void'($urandom(86));
      cyc(6);
      check(brake, 0);
      aresetn <= 1'b1;
      cyc(4);
      check(cap, 1);
      rchk(`MBS_ADR_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
      rchk(`MBS_ADR_ECO_DLY, 32'h0000_FFFF, 32'h0000_0064);
      rchk(`MBS_ADR_SW_DLY, 32'h0000_FFFF, 32'h0000_0064);
      rchk(`MBS_ADR_INT_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
      rchk(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
      wr(`MBS_ADR_STATUS, 32'h0000_0001, `MBS_RESP_ERR);
      wr(`MBS_ADR_CTRL, 32'h0000_0001, `MBS_RESP_OK);
      wr(`MBS_ADR_ECO_DLY, 32'h0000_0003, `MBS_RESP_OK);
      wr(`MBS_ADR_SW_DLY, 32'h0000_0005, `MBS_RESP_OK);
      // Release, masked then unmasked interrupt, locked settings.
      en <= 1'b1;
      cyc(3);
      check(brake, 1);
      check(irq, 0);
      wr(`MBS_ADR_CTRL, 32'h0000_0000, `MBS_RESP_ERR);
      wr(`MBS_ADR_INT_MASK, 32'h0000_003F, `MBS_RESP_OK);
      cyc(2);
      check(irq, 1);
      rchk(`MBS_ADR_INT_STAT, 32'h0000_0001, 32'h0000_0001);
      cyc(2);
      check(irq, 0);
      // Withdrawn enable: brake falls, windings stay fed for the delay.
      en <= 1'b0;
      cyc(2);
      check(brake, 0);
      cyc(8);
      check(cur, 1);
      cyc(25);
      check(cur, 0);
      // Fault, then load-voltage loss, while released.
      for (int k = 0; k < 2; k++) begin
         en <= 1'b1;
         cyc(4);
         check(brake, 1);
         if (k == 0) fault <= 1'b1;
         else volt <= 1'b0;
         cyc(2);
         check(brake, 0);
         check(cur, 0);
         {fault, volt, en} <= 3'b010;
         cyc(40);
      end
      // Idle mode after a move stops.
      wr(`MBS_ADR_CTRL, 32'h0000_0003, `MBS_RESP_OK);
      move <= 1'b1;
      en <= 1'b1;
      cyc(12);
      check(motion, 1);
      move <= 1'b0;
      cyc(5);
      check(brake, 1);
      cyc(11);
      check(brake, 0);
      check(cur, 1);
      cyc(30);
      check(cur, 0);
      en <= 1'b0;
      cyc(30);
      // Closed loop refused without encoder, then boost and hold limits.
      wr(`MBS_ADR_CTRL, 32'h0000_0004, `MBS_RESP_OK);
      ecfg <= 1'b1;
      en <= 1'b1;
      cyc(4);
      check(cl, 0);
      rchk(`MBS_ADR_INT_STAT, 32'h0000_0008, 32'h0000_0008);
      econ <= 1'b1;
      cyc(3);
      check(cl, 1);
      check(boost, 0);
      check(cap, 0);
      rchk(`MBS_ADR_STATUS, 32'h0000_001F, 32'h0000_0012);
      accel <= 1'b1;
      cyc(3);
      check(boost, 1);
      cyc(CPM * 2000 + 20);
      check(boost, 0);
      check(cap, 1);
      rchk(`MBS_ADR_INT_STAT, 32'h0000_0004, 32'h0000_0004);
      {accel, en} <= 2'b00;
      // Local writes: rejected under the fieldbus, applied otherwise.
      rnd = {16'h0000, 16'($urandom)};
      fbus <= 1'b1;
      lwr(`MBS_ADR_ECO_DLY, rnd);
      rchk(`MBS_ADR_ECO_DLY, 32'h0000_FFFF, 32'h0000_0003);
      rchk(`MBS_ADR_INT_STAT, 32'h0000_0010, 32'h0000_0010);
      fbus <= 1'b0;
      lwr(`MBS_ADR_ECO_DLY, rnd);
      rchk(`MBS_ADR_ECO_DLY, 32'h0000_FFFF, rnd);
      // Tuning results take effect at once.
      for (int k = 0; k < 3; k++) begin
         tkp <= 16'($urandom);
         tki <= 16'($urandom);
         tdone <= 1'b1;
         cyc(1);
         tdone <= 1'b0;
         cyc(1);
         check(kp, tkp);
         rchk(`MBS_ADR_CTL_PAR, 32'hFFFF_FFFF, {tki, tkp});
      end
      report_and_stop;
   end
endmodule
`default_nettype wire
